// ### prom_pkg.sv
package prom_pkg;
  // =====================================================
  // storage geometry
  localparam int CAPACITY_BITS = 4096;
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 16;
  // =====================================================
  // programmed options
  localparam bit RESET_ACTIVE_HIGH = 1'b1;
  // =====================================================
  // pin vector positions in the synchroniser
  localparam int PIN_RESET = 0;
  localparam int PIN_CE_N = 1;
  localparam int PIN_CLK = 2;
  localparam int PIN_COUNT = 3;
endpackage

// ### serial_config_prom_read.sv
// How it works
// R1: data pin released unless chip and output enabled
// R2: host clock rise advances counter when enabled
// R3: reset holds counter zero, data released
// R4: reset pin polarity is a programmed option
// R5: chip enable high stops, releases, enters standby
// R6: cascade low when enabled and past last address
// R7: exhausted cascade follows enable; high after reset
// R8: cascade out feeds next chip enable in chain
// R9: next bit presented shortly after each rise
// R10: host issues exactly the needed clock pulses
// R11: host disables memory after configuration
// R12: slave mode clocks both from one source
// R13: host init output drives memory reset input
// R14: last address parameter; counter stops past it
`timescale 1ns/1ps

// =====================================================
// word fifo between storage array and serialiser
module prom_word_fifo #(
  parameter int WIDTH = prom_pkg::WORD_W,
  parameter int DEPTH = prom_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop, full, empty;

  always_comb begin
    full = (wr_r[PW] != rd_r[PW]) && (wr_r[PW-1:0] == rd_r[PW-1:0]);
    empty = (wr_r == rd_r);
    in_ready = ~full;
    out_valid = ~empty;
    out_data = mem[rd_r[PW-1:0]];
    push = in_valid & ~full;
    pop = out_ready & ~empty;
    wr_nxt = wr_r + (PW+1)'(push);
    rd_nxt = rd_r + (PW+1)'(pop);
    if (flush) begin
      wr_nxt = '0;
      rd_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[PW-1:0]] <= in_data;
    end
  end
endmodule // prom_word_fifo

// =====================================================
// serial configuration memory, read side
module serial_config_prom_read #(
  parameter int CAPACITY_BITS = prom_pkg::CAPACITY_BITS,
  parameter int WORD_W = prom_pkg::WORD_W,
  parameter int FIFO_DEPTH = prom_pkg::FIFO_DEPTH,
  parameter bit RESET_ACTIVE_HIGH = prom_pkg::RESET_ACTIVE_HIGH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic host_configuration_clock,
  input wire logic chip_enable_n,
  input wire logic reset_oe,
  input wire logic prog_we,
  input wire logic [$clog2(CAPACITY_BITS/WORD_W)-1:0] prog_addr,
  input wire logic [WORD_W-1:0] prog_data,
  output logic data_out,
  output logic data_oe,
  output logic cascade_select_out,
  output logic standby
);
  localparam int WORDS = CAPACITY_BITS / WORD_W;
  localparam int WA = $clog2(WORDS);
  localparam int AW = $clog2(CAPACITY_BITS) + 1;
  localparam int BW = $clog2(WORD_W);
  localparam logic [AW-1:0] LAST_ADDRESS_VALUE = AW'(CAPACITY_BITS - 1);
  localparam logic [BW-1:0] LAST_BIT = BW'(WORD_W - 1);
  localparam int NP = prom_pkg::PIN_COUNT;
  // idle pin levels: enable off, reset asserted, clock low
  localparam logic [NP-1:0] PIN_IDLE = {1'b0, 1'b1, RESET_ACTIVE_HIGH};

  // =====================================================
  // pin synchronisers; the host clock is sampled, so it must stay
  // well below a quarter of clk
  logic [NP-1:0] meta_r, meta_nxt, sync_r, sync_nxt;
  logic ck_prev_r, ck_prev_nxt;

  always_comb begin
    meta_nxt = {host_configuration_clock, chip_enable_n, reset_oe};
    sync_nxt = meta_r;
    ck_prev_nxt = sync_r[prom_pkg::PIN_CLK];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= PIN_IDLE;
      sync_r <= PIN_IDLE;
      ck_prev_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      ck_prev_r <= ck_prev_nxt;
    end
  end

  logic [AW-1:0] addr_r, addr_nxt;
  logic reset_asserted, ce_active, enabled, clk_rise, exhausted, advance, flush;

  always_comb begin
    // polarity fixed when the part is programmed
    reset_asserted = RESET_ACTIVE_HIGH ? sync_r[prom_pkg::PIN_RESET]
                                       : ~sync_r[prom_pkg::PIN_RESET]; // R4
    ce_active = ~sync_r[prom_pkg::PIN_CE_N];
    enabled = ce_active & ~reset_asserted;
    clk_rise = sync_r[prom_pkg::PIN_CLK] & ~ck_prev_r;
    exhausted = addr_r > LAST_ADDRESS_VALUE; // R14
    advance = clk_rise & enabled & ~exhausted; // R2 R5 R14
    flush = sys_rst | reset_asserted; // R3
  end

  // =====================================================
  // storage array and prefetch into the fifo
  logic [WORD_W-1:0] store [WORDS];
  logic [WA:0] fetch_r, fetch_nxt;
  logic fill_valid, fill_ready, word_valid, word_ready;
  logic [WORD_W-1:0] word_data;

  always_ff @(posedge clk) begin
    if (prog_we) begin
      store[prog_addr] <= prog_data;
    end
  end

  always_comb begin
    fill_valid = (fetch_r < (WA+1)'(WORDS));
    fetch_nxt = fetch_r + (WA+1)'(fill_valid & fill_ready);
    if (flush) begin
      fetch_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetch_r <= '0;
    end else begin
      fetch_r <= fetch_nxt;
    end
  end

  prom_word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(flush),
    .in_valid(fill_valid & ~flush),
    .in_ready(fill_ready),
    .in_data(store[fetch_r[WA-1:0]]),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );

  // =====================================================
  // address counter and serialiser, msb of each word first
  logic [WORD_W-1:0] shift_r, shift_nxt;
  logic [BW-1:0] bit_r, bit_nxt;
  logic loaded_r, loaded_nxt;
  logic data_r, data_nxt;
  logic word_end;

  always_comb begin
    addr_nxt = addr_r;
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    loaded_nxt = loaded_r;
    word_end = advance & (bit_r == LAST_BIT);
    // a stalled serialiser leaves words in the fifo
    word_ready = ~flush & (~loaded_r | word_end);
    if (advance) begin
      addr_nxt = addr_r + AW'(1); // R2
      bit_nxt = bit_r + BW'(1);
      shift_nxt = {shift_r[WORD_W-2:0], 1'b0}; // R9
      if (word_end) begin
        loaded_nxt = 1'b0;
      end
    end
    if (word_ready & word_valid) begin
      shift_nxt = word_data;
      loaded_nxt = 1'b1;
    end
    data_nxt = shift_nxt[WORD_W-1]; // R9
    if (flush) begin
      addr_nxt = '0; // R3
      bit_nxt = '0;
      loaded_nxt = 1'b0;
      shift_nxt = '0;
      data_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_r <= '0;
      shift_r <= '0;
      bit_r <= '0;
      loaded_r <= 1'b0;
      data_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      loaded_r <= loaded_nxt;
      data_r <= data_nxt;
    end
  end

  // =====================================================
  // pins; the line is released once exhausted so the next part can drive it
  always_comb begin
    data_out = data_r;
    data_oe = enabled & ~exhausted; // R1 R3 R5 R8
    cascade_select_out = ~(enabled & exhausted); // R6 R7 R8
    standby = ~ce_active; // R5
  end
endmodule // serial_config_prom_read

// ### prom_read_chk.sv
`timescale 1ns/1ps
// ==========
// pin-level checks, pins pass two sync flops
module prom_read_chk #(
  parameter bit RESET_ACTIVE_HIGH = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_enable_n,
  input wire logic reset_oe,
  input wire logic data_oe,
  input wire logic cascade_select_out,
  input wire logic standby
);
  default clocking @(posedge clk); endclocking
  // the reset pin polarity is programmed per part, so follow its setting
  wire logic rst_on = RESET_ACTIVE_HIGH ? reset_oe : !reset_oe;
  default disable iff (sys_rst);
  sequence ce_off_s; chip_enable_n [*3]; endsequence
  sequence rst_on_s; rst_on [*3]; endsequence
  a_ce_off_release: assert property (ce_off_s |-> !data_oe && standby)
    else $error("data driven while deselected");
  a_rst_release: assert property (rst_on_s |-> !data_oe && cascade_select_out)
    else $error("data or cascade active in reset");
  a_ce_off_casc: assert property (ce_off_s |-> cascade_select_out)
    else $error("cascade low while deselected");
  a_ce_on_awake: assert property (!chip_enable_n [*3] |-> !standby)
    else $error("standby while selected");
  a_oe_casc_excl: assert property (!(data_oe && !cascade_select_out))
    else $error("driving data with cascade low");
  a_oe_rise_cause: assert property ($rose(data_oe) |->
    !$past(chip_enable_n, 2) && !$past(rst_on, 2))
    else $error("data drive began while disabled");
  a_sb_rise_cause: assert property ($rose(standby) |-> $past(chip_enable_n, 2))
    else $error("standby without deselect");
  a_casc_fall_cause: assert property ($fell(cascade_select_out) |->
    !$past(chip_enable_n, 2) && !$past(rst_on, 2))
    else $error("cascade fell while disabled");
endmodule // prom_read_chk

bind serial_config_prom_read prom_read_chk #(.RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH))
  prom_read_chk_i (.clk, .sys_rst, .chip_enable_n,
  .reset_oe, .data_oe, .cascade_select_out, .standby);

// ### prom_host_model.sv
`timescale 1ns/1ps
// ==========
// host configuration controller
module prom_host_model (
  input wire logic clk,
  input wire logic data_out,
  input wire logic data_oe,
  output logic host_configuration_clock,
  output logic [63:0] got
);
  // host input has a pull-up
  wire logic din = data_oe ? data_out : 1'b1;
  initial begin
    host_configuration_clock = 1'b0;
    got = '0;
  end
  // sample, then rise; exactly n pulses from the shared clock
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      @(posedge clk);
      got <= {got[62:0], din};
      host_configuration_clock <= 1'b1;
      repeat (half) @(posedge clk);
      host_configuration_clock <= 1'b0;
      repeat (half) @(posedge clk);
    end
  endtask
endmodule // prom_host_model

// ### serial_config_prom_read_tb.sv
`timescale 1ns/1ps
module serial_config_prom_read_tb;
  localparam int CAP = 64;
  localparam logic [63:0] IMG = 64'hC3A5_0F96_3C5A_F069;
  logic clk, sys_rst, ce_n, rst_oe, prog_we, data_out, data_oe, casc, standby, hclk;
  logic [2:0] prog_addr;
  logic [7:0] prog_data;
  logic [63:0] got;
  logic lo_oe, lo_casc, lo_sb;
  wire logic rst_oe_n = ~rst_oe;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // ce_n, reset_oe, then data_oe, cascade, standby
  logic [4:0] rows [4] = '{5'b1_0_011, 5'b0_1_010, 5'b0_0_110, 5'b1_1_011};
  serial_config_prom_read #(.CAPACITY_BITS(CAP)) serial_config_prom_read_i (.clk, .sys_rst,
    .host_configuration_clock(hclk), .chip_enable_n(ce_n), .reset_oe(rst_oe), .prog_we,
    .prog_addr, .prog_data, .data_out, .data_oe, .cascade_select_out(casc), .standby);
  prom_host_model prom_host_model_i (.clk, .data_out, .data_oe,
    .host_configuration_clock(hclk), .got);
  // same part with the reset pin programmed active low, driven inverted
  serial_config_prom_read #(.CAPACITY_BITS(CAP), .RESET_ACTIVE_HIGH(1'b0))
    serial_config_prom_read_lo_i (.clk, .sys_rst, .host_configuration_clock(hclk),
    .chip_enable_n(ce_n), .reset_oe(rst_oe_n), .prog_we, .prog_addr, .prog_data,
    .data_out(), .data_oe(lo_oe), .cascade_select_out(lo_casc), .standby(lo_sb));
  // ==========
  // clock, timeout, reporting
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // look at negedge so combinational outputs have settled
  task automatic pins(input logic c, input logic r, input int n, input logic [2:0] exp);
    ce_n <= c;
    rst_oe <= r;
    repeat (n) @(posedge clk);
    @(negedge clk);
    check({data_oe, casc, standby}, exp);
    check({lo_oe, lo_casc, lo_sb}, exp);
    @(posedge clk);
  endtask
  // ==========
  // main sequence
  initial begin
    {sys_rst, ce_n, rst_oe, prog_we} = 4'b1110;
    prog_addr = '0;
    prog_data = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      prog_we <= 1'b1;
      prog_addr <= i[2:0];
      prog_data <= IMG[63-8*i -: 8];
      @(posedge clk);
    end
    prog_we <= 1'b0;
    foreach (rows[i]) pins(rows[i][4], rows[i][3], 4, rows[i][2:0]);
    pins(1'b0, 1'b1, 4, 3'b010);
    pins(1'b0, 1'b0, 10, 3'b110);
    prom_host_model_i.pulses(8, 4);
    check(got[7:0], IMG[63:56]);
    pins(1'b1, 1'b0, 3, 3'b011);
    // rises while deselected must not move the counter
    prom_host_model_i.pulses(4, 4);
    pins(1'b0, 1'b0, 10, 3'b110);
    prom_host_model_i.pulses(8, 6);
    check(got[7:0], IMG[55:48]);
    pins(1'b0, 1'b1, 4, 3'b010);
    pins(1'b0, 1'b0, 10, 3'b110);
    prom_host_model_i.pulses(CAP, 4);
    check(got, IMG);
    pins(1'b0, 1'b0, 6, 3'b000);
    prom_host_model_i.pulses(3, 4);
    pins(1'b0, 1'b0, 6, 3'b000);
    pins(1'b1, 1'b0, 4, 3'b011);
    pins(1'b0, 1'b0, 4, 3'b000);
    pins(1'b0, 1'b1, 4, 3'b010);
    pins(1'b0, 1'b0, 10, 3'b110);
    sys_rst <= 1'b1;
    pins(1'b0, 1'b0, 3, 3'b011);
    sys_rst <= 1'b0;
    // system reset cleared the counter, so driving resumes with cascade high
    pins(1'b0, 1'b0, 4, 3'b110);
    give_verdict();
  end
endmodule // serial_config_prom_read_tb
